// ---- shared/ccd_timing_cfg.svh ----
// Purpose: Constants for the fine-edge timing generator
// Assumes: Included by the package and the top timing module
// Notes: Register index times four gives the APB byte address
`ifndef CCD_TIMING_CFG_SVH
`define CCD_TIMING_CFG_SVH
// Timing core
`define STEPS_PER_PIXEL 48
`define EDGES_PER_QUAD 12
`define SYNC_DELAY_PIXELS 7
// Register indexes
`define IDX_OPERATION 8'h00
`define IDX_OUTPUT_CONTROL 8'h03
`define IDX_H1_CONTROL 8'h60
`define IDX_RG_CONTROL 8'h61
`define IDX_DRIVER_STRENGTH 8'h62
`define IDX_SAMPLE_CONTROL 8'h63
`define IDX_OUTPUT_PHASE 8'h64
`define IDX_AUX_TIMING 8'h65
`define IDX_STATUS 8'h66
// Reset values
`define RST_OPERATION 12'h004
`define RST_OUTPUT_CONTROL 6'h04
`define RST_H1_CONTROL 13'h1001
`define RST_RG_CONTROL 13'h0801
`define RST_DRIVER_STRENGTH 15'h0000
`define RST_SAMPLE_CONTROL 12'h024
`define RST_OUTPUT_PHASE 6'h00
`define RST_AUX_TIMING 7'h00
// Field positions
`define OP_CLAMP_ON 2
`define OP_CLAMP_SPEED 3
`define OP_QUICK_CLAMP 4
`define OP_BLANK_LEVEL 5
`define OP_RESTORE_BYP 8
`define OC_TRISTATE 3
`define OC_TRANSPARENT 4
`define OC_GRAY 5
`define CTL_INVERT 0
`define AUX_SYNC_EDGE 6
`endif

// ---- shared/ccd_timing_pkg.sv ----
// Purpose: Types and helpers for the fine-edge timing generator
// Assumes: ccd_timing_cfg.svh holds every number
// Notes: Edge codes are quadrant coded, see edge_pos
`include "ccd_timing_cfg.svh"
package ccd_timing_pkg;
    // Line sync tracker, Gray coded from IDLE to WAIT to HIT
    typedef enum logic [1:0] {
        SYNC_IDLE = 2'h0,
        SYNC_WAIT = 2'h1,
        SYNC_HIT = 2'h3
    } sync_state_t;

    typedef logic [5:0] edge_code_t;

    // Quadrant code to linear position 0..47
    function automatic logic [5:0] edge_pos(input edge_code_t c);
        edge_pos = 6'({4'h0, c[5:4]} * 6'(`EDGES_PER_QUAD))
            + {2'h0, c[3:0]};
    endfunction

    // Low nibble above 11 places no edge at all
    function automatic logic edge_ok(input edge_code_t c);
        edge_ok = c[3:0] < 4'(`EDGES_PER_QUAD);
    endfunction
endpackage

// ---- shared/fine_phase_if.sv ----
// Purpose: Fine phase and enable shared by the timing submodules
// Assumes: One source drives phase and ce
// Notes: phase runs 0..47 within each pixel period
interface fine_phase_if;
    logic [5:0] phase;
    logic ce;
    modport src (output phase, output ce);
    modport snk (input phase, input ce);
endinterface

// ---- hdl/edge_place.sv ----
// Purpose: One programmable rise/fall waveform on the fine grid
// Assumes: Codes are quadrant coded edge locations
// Notes: Rise wins when both codes land on the same step
module edge_place
    import ccd_timing_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Fine phase
    fine_phase_if.snk tim,
    // Edge codes
    input wire edge_code_t rise_code,
    input wire edge_code_t fall_code,
    // Waveform, before polarity
    output logic level
);
    logic rise_hit;
    logic fall_hit;

    // Quadrant decode and compare
    assign rise_hit = edge_ok(rise_code)
        && (edge_pos(rise_code) == tim.phase);
    assign fall_hit = edge_ok(fall_code)
        && (edge_pos(fall_code) == tim.phase);

    // Level holds between edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level <= 1'b0;
        end else if (tim.ce) begin
            if (rise_hit) begin
                level <= 1'b1;
            end else if (fall_hit) begin
                level <= 1'b0;
            end
        end
    end
endmodule // edge_place

// ---- hdl/output_word.sv ----
// Purpose: Output word blanking, coding and phase latch
// Assumes: conv_data and pre_blank come from pclk logic
// Notes: Transparent mode follows the data every step
module output_word
    import ccd_timing_pkg::*;
#(
    parameter int DATA_W = 14
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Fine phase
    fine_phase_if.snk tim,
    // Control
    input wire edge_code_t latch_code,
    input wire logic transparent,
    input wire logic gray,
    input wire logic pre_blank,
    input wire logic blank_level,
    // Data
    input wire logic [DATA_W-1:0] conv_data,
    input wire logic [DATA_W-1:0] clamp_level,
    output logic [DATA_W-1:0] word
);
    logic [DATA_W-1:0] blanked;
    logic [DATA_W-1:0] coded;
    logic latch_hit;

    // Blank to zero or clamp level
    assign blanked = !pre_blank ? conv_data
        : (blank_level ? clamp_level : '0);
    assign coded = gray ? (blanked ^ (blanked >> 1)) : blanked;
    assign latch_hit = edge_ok(latch_code)
        && (edge_pos(latch_code) == tim.phase);

    // Register on the chosen step unless transparent
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word <= '0;
        end else if (tim.ce && (transparent || latch_hit)) begin
            word <= coded;
        end
    end
endmodule // output_word

// ---- hdl/ccd_fine_edge_timing_gen.sv ----
// Purpose: Fine-edge timing generator for one CCD front-end channel
// Assumes: pclk is one fine step, so a pixel spans 48 pclk cycles
// Notes: APB slave, zero wait states, registers one word each
`include "ccd_timing_cfg.svh"
module ccd_fine_edge_timing_gen
    import ccd_timing_pkg::*;
#(
    parameter int STEPS = `STEPS_PER_PIXEL,
    parameter int DATA_W = 14,
    parameter int HCNT_W = 12
) (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Line sync pin
    input wire logic line_sync_input,
    // Front-end data and events, pclk domain
    input wire logic [DATA_W-1:0] conv_data,
    input wire logic [DATA_W-1:0] clamp_level,
    input wire logic pre_blanking,
    input wire logic optical_black_clamp,
    input wire logic gain_update,
    // CCD clocks and strobes
    output logic reset_gate_pulse,
    output logic horizontal_clock_one,
    output logic horizontal_clock_two,
    output logic horizontal_clock_three,
    output logic horizontal_clock_four,
    output logic reset_level_strobe,
    output logic data_level_strobe,
    // Driver controls, enables low while driving
    output logic [14:0] driver_current_codes,
    output logic [3:0] hclk_oe_n,
    output logic reset_gate_oe_n,
    // Data outputs
    output logic [DATA_W-1:0] data_out,
    output logic data_out_oe_n,
    // Analog front-end controls
    output logic [1:0] power_state_select,
    output logic reference_standby,
    output logic total_power_down,
    output logic clamp_active,
    output logic clamp_settling_speed,
    output logic quick_clamp_pulse,
    output logic restore_bypassed,
    // Pixel counter
    output logic [HCNT_W-1:0] pixel_count
);
    // Fine grid and edge codes are six bits wide
    if (STEPS != `STEPS_PER_PIXEL) begin : g_bad_steps
        $error("STEPS must match the six-bit quadrant edge code");
    end
    if (DATA_W < 2 || DATA_W > 30 || HCNT_W < 4 || HCNT_W > 16)
    begin : g_bad_width
        $error("DATA_W or HCNT_W out of range");
    end

    // Register file
    logic [11:0] front_end_operation;
    logic [5:0] front_end_output_control;
    logic [12:0] h1_control;
    logic [12:0] rg_control;
    logic [14:0] clock_driver_strength;
    logic [11:0] sample_control;
    logic [5:0] output_data_phase;
    logic [6:0] aux_timing;

    // APB decode
    logic [7:0] reg_idx;
    logic setup_phase;
    logic wr_en;
    logic hit_op;
    logic hit_oc;
    logic hit_h1;
    logic hit_rg;
    logic hit_drv;
    logic hit_samp;
    logic hit_phase;
    logic hit_aux;
    logic hit_status;
    logic mapped;
    logic [31:0] next_prdata;
    logic [31:0] status_word;

    // Timing core
    fine_phase_if tim ();
    logic [5:0] phase;
    logic pixel_wrap;
    logic h1_level;
    logic h3_level;
    logic rg_level;
    logic shp_hit;
    logic shd_hit;
    logic [DATA_W-1:0] word;

    // Line sync
    logic [2:0] sync_pipe;
    logic sync_level;
    logic sync_prev;
    logic sync_edge;
    sync_state_t sync_state;
    sync_state_t next_sync_state;
    logic [2:0] sync_wait;

    // Address decode, word aligned
    assign reg_idx = paddr[9:2];
    assign setup_phase = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite && !pslverr;
    assign hit_op = (reg_idx == `IDX_OPERATION);
    assign hit_oc = (reg_idx == `IDX_OUTPUT_CONTROL);
    assign hit_h1 = (reg_idx == `IDX_H1_CONTROL);
    assign hit_rg = (reg_idx == `IDX_RG_CONTROL);
    assign hit_drv = (reg_idx == `IDX_DRIVER_STRENGTH);
    assign hit_samp = (reg_idx == `IDX_SAMPLE_CONTROL);
    assign hit_phase = (reg_idx == `IDX_OUTPUT_PHASE);
    assign hit_aux = (reg_idx == `IDX_AUX_TIMING);
    assign hit_status = (reg_idx == `IDX_STATUS);
    assign mapped = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0)
        && (hit_op || hit_oc || hit_h1 || hit_rg || hit_drv
        || hit_samp || hit_phase || hit_aux || hit_status);

    // Status shows counter, filtered sync level and sync wait
    assign status_word = {14'h0000, sync_state == SYNC_WAIT,
        sync_level, 16'(pixel_count)};

    // Read mux, narrow registers sit in the low bits
    always_comb begin
        if (hit_op) begin
            next_prdata = {20'h00000, front_end_operation};
        end else if (hit_oc) begin
            next_prdata = {26'h0000000, front_end_output_control};
        end else if (hit_h1) begin
            next_prdata = {19'h00000, h1_control};
        end else if (hit_rg) begin
            next_prdata = {19'h00000, rg_control};
        end else if (hit_drv) begin
            next_prdata = {17'h00000, clock_driver_strength};
        end else if (hit_samp) begin
            next_prdata = {20'h00000, sample_control};
        end else if (hit_phase) begin
            next_prdata = {26'h0000000, output_data_phase};
        end else if (hit_aux) begin
            next_prdata = {25'h0000000, aux_timing};
        end else if (hit_status) begin
            next_prdata = status_word;
        end else begin
            next_prdata = 32'h00000000;
        end
    end

    // Answer prepared in setup, so access phase completes at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (clk_en) begin
            pready <= setup_phase;
            pslverr <= setup_phase && !mapped;
            if (setup_phase && !pwrite) begin
                prdata <= mapped ? next_prdata : 32'h00000000;
            end
        end
    end

    // Register writes; test bits are stored as software leaves them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            front_end_operation <= `RST_OPERATION;
            front_end_output_control <= `RST_OUTPUT_CONTROL;
            h1_control <= `RST_H1_CONTROL;
            rg_control <= `RST_RG_CONTROL;
            clock_driver_strength <= `RST_DRIVER_STRENGTH;
            sample_control <= `RST_SAMPLE_CONTROL;
            output_data_phase <= `RST_OUTPUT_PHASE;
            aux_timing <= `RST_AUX_TIMING;
        end else if (clk_en && wr_en) begin
            if (hit_op) begin
                front_end_operation <= pwdata[11:0];
            end else if (hit_oc) begin
                front_end_output_control <= pwdata[5:0];
            end else if (hit_h1) begin
                h1_control <= pwdata[12:0];
            end else if (hit_rg) begin
                rg_control <= pwdata[12:0];
            end else if (hit_drv) begin
                clock_driver_strength <= pwdata[14:0];
            end else if (hit_samp) begin
                sample_control <= pwdata[11:0];
            end else if (hit_phase) begin
                output_data_phase <= pwdata[5:0];
            end else if (hit_aux) begin
                aux_timing <= pwdata[6:0];
            end
        end
    end

    // Fine step counter, one pclk per step
    assign pixel_wrap = (phase == 6'(STEPS - 1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 6'h00;
        end else if (clk_en) begin
            phase <= pixel_wrap ? 6'h00 : phase + 6'h01;
        end
    end
    assign tim.phase = phase;
    assign tim.ce = clk_en;

    // Edge generators; H3 falls with H1, it has no fall field
    edge_place u_h1 (
        .pclk(pclk),
        .presetn(presetn),
        .tim(tim),
        .rise_code(h1_control[6:1]),
        .fall_code(h1_control[12:7]),
        .level(h1_level)
    );
    edge_place u_h3 (
        .pclk(pclk),
        .presetn(presetn),
        .tim(tim),
        .rise_code(aux_timing[5:0]),
        .fall_code(h1_control[12:7]),
        .level(h3_level)
    );
    edge_place u_rg (
        .pclk(pclk),
        .presetn(presetn),
        .tim(tim),
        .rise_code(rg_control[6:1]),
        .fall_code(rg_control[12:7]),
        .level(rg_level)
    );

    // Strobes are one fine step wide
    assign shp_hit = edge_ok(sample_control[5:0])
        && (edge_pos(sample_control[5:0]) == phase);
    assign shd_hit = edge_ok(sample_control[11:6])
        && (edge_pos(sample_control[11:6]) == phase);

    // Output flops; H2 and H4 share H1 so they never drift apart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            horizontal_clock_one <= 1'b0;
            horizontal_clock_two <= 1'b1;
            horizontal_clock_three <= 1'b0;
            horizontal_clock_four <= 1'b1;
            reset_gate_pulse <= 1'b0;
            reset_level_strobe <= 1'b0;
            data_level_strobe <= 1'b0;
        end else if (clk_en) begin
            horizontal_clock_one <= h1_level
                ^ h1_control[`CTL_INVERT];
            horizontal_clock_two <= !(h1_level
                ^ h1_control[`CTL_INVERT]);
            horizontal_clock_three <= h3_level;
            horizontal_clock_four <= !(h1_level
                ^ h1_control[`CTL_INVERT]);
            reset_gate_pulse <= rg_level
                ^ rg_control[`CTL_INVERT];
            reset_level_strobe <= shp_hit;
            data_level_strobe <= shd_hit;
        end
    end

    // Driver enables, code zero means off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hclk_oe_n <= 4'hF;
            reset_gate_oe_n <= 1'b1;
        end else if (clk_en) begin
            for (int i = 0; i < 4; i++) begin
                hclk_oe_n[i] <= (clock_driver_strength[3*i +: 3]
                    == 3'h0);
            end
            reset_gate_oe_n <= (clock_driver_strength[14:12]
                == 3'h0);
        end
    end
    assign driver_current_codes = clock_driver_strength;

    // Output word path
    output_word #(.DATA_W(DATA_W)) u_word (
        .pclk(pclk),
        .presetn(presetn),
        .tim(tim),
        .latch_code(output_data_phase),
        .transparent(front_end_output_control[`OC_TRANSPARENT]),
        .gray(front_end_output_control[`OC_GRAY]),
        .pre_blank(pre_blanking),
        .blank_level(front_end_operation[`OP_BLANK_LEVEL]),
        .conv_data(conv_data),
        .clamp_level(clamp_level),
        .word(word)
    );
    assign data_out = word;

    // Front-end controls, all registered except power_state_select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_out_oe_n <= 1'b1;
            reference_standby <= 1'b0;
            total_power_down <= 1'b0;
            clamp_active <= 1'b0;
            clamp_settling_speed <= 1'b0;
            quick_clamp_pulse <= 1'b0;
            restore_bypassed <= 1'b0;
        end else if (clk_en) begin
            data_out_oe_n <=
                front_end_output_control[`OC_TRISTATE];
            reference_standby <=
                (front_end_operation[1:0] == 2'h1);
            total_power_down <= front_end_operation[1];
            clamp_active <= optical_black_clamp
                && front_end_operation[`OP_CLAMP_ON];
            clamp_settling_speed <=
                front_end_operation[`OP_CLAMP_SPEED];
            quick_clamp_pulse <= gain_update
                && front_end_operation[`OP_QUICK_CLAMP];
            restore_bypassed <= pre_blanking
                && front_end_operation[`OP_RESTORE_BYP];
        end
    end
    assign power_state_select = front_end_operation[1:0];

    // Pin synchroniser; level moves once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_pipe <= 3'h7;
            sync_level <= 1'b1;
            sync_prev <= 1'b1;
        end else if (clk_en) begin
            sync_pipe <= {sync_pipe[1:0], line_sync_input};
            if (sync_pipe[1] == sync_pipe[2]) begin
                sync_level <= sync_pipe[2];
            end
            sync_prev <= sync_level;
        end
    end

    // Falling edge by default, rising when selected
    assign sync_edge = aux_timing[`AUX_SYNC_EDGE]
        ? (sync_level && !sync_prev) : (!sync_level && sync_prev);

    // A new edge while waiting restarts the delay
    always_comb begin
        next_sync_state = sync_state;
        case (sync_state)
            SYNC_IDLE: begin
                if (sync_edge) begin
                    next_sync_state = SYNC_WAIT;
                end
            end
            SYNC_WAIT: begin
                if (!sync_edge && pixel_wrap
                    && sync_wait == 3'(`SYNC_DELAY_PIXELS - 1)) begin
                    next_sync_state = SYNC_HIT;
                end
            end
            SYNC_HIT: begin
                next_sync_state = sync_edge ? SYNC_WAIT : SYNC_IDLE;
            end
            default: begin
                next_sync_state = SYNC_IDLE;
            end
        endcase
    end

    // Delay counts pixel periods, then clears the pixel counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_state <= SYNC_IDLE;
            sync_wait <= 3'h0;
            pixel_count <= '0;
        end else if (clk_en) begin
            sync_state <= next_sync_state;
            if (sync_edge) begin
                sync_wait <= 3'h0;
            end else if (sync_state == SYNC_WAIT && pixel_wrap) begin
                sync_wait <= sync_wait + 3'h1;
            end
            if (sync_state == SYNC_HIT) begin
                pixel_count <= '0;
            end else if (pixel_wrap) begin
                pixel_count <= pixel_count + HCNT_W'(1);
            end
        end
    end
endmodule // ccd_fine_edge_timing_gen

// ---- verif/ccd_timing_monitor.sv ----
// Purpose: Port checker for the timing generator
// Assumes: One pclk domain
// Notes: Registered outputs lag their fields by one edge
module ccd_timing_monitor (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Watched ports
    input wire logic horizontal_clock_one,
    input wire logic horizontal_clock_two,
    input wire logic horizontal_clock_four,
    input wire logic [14:0] driver_current_codes,
    input wire logic [3:0] hclk_oe_n,
    input wire logic reset_gate_oe_n,
    input wire logic [1:0] power_state_select,
    input wire logic reference_standby,
    input wire logic total_power_down,
    input wire logic gain_update,
    input wire logic quick_clamp_pulse,
    input wire logic reset_level_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Strobe is followed by at least eight quiet fine steps
    sequence s_quiet;
        !reset_level_strobe [*8];
    endsequence
    a_h2_inverse: assert property (
        horizontal_clock_two == !horizontal_clock_one) else $error("h2");
    a_h4_inverse: assert property (
        horizontal_clock_four == !horizontal_clock_one) else $error("h4");
    a_h1_drv_off: assert property (
        $stable(driver_current_codes[2:0]) |->
        hclk_oe_n[0] == (driver_current_codes[2:0] == 3'h0)) else $error("oe");
    a_rg_drv_off: assert property (
        $stable(driver_current_codes[14:12]) |->
        reset_gate_oe_n == (driver_current_codes[14:12] == 3'h0))
        else $error("rg oe");
    a_pwr_modes: assert property (
        $stable(power_state_select) |->
        {total_power_down, reference_standby} ==
        {power_state_select[1], power_state_select == 2'h1}) else $error("pwr");
    a_quick_cause: assert property (
        quick_clamp_pulse |-> $past(gain_update)) else $error("quick");
    a_strobe_gap: assert property (
        reset_level_strobe |=> s_quiet) else $error("strobe gap");
    a_strobe_period: assert property (
        reset_level_strobe |-> ##48 reset_level_strobe) else $error("period");
endmodule // ccd_timing_monitor

bind ccd_fine_edge_timing_gen ccd_timing_monitor u_mon (.pclk, .presetn,
    .horizontal_clock_one, .horizontal_clock_two, .horizontal_clock_four,
    .driver_current_codes, .hclk_oe_n, .reset_gate_oe_n, .power_state_select,
    .reference_standby, .total_power_down, .gain_update, .quick_clamp_pulse,
    .reset_level_strobe);

// ---- verif/ccd_sensor_model.sv ----
// Purpose: Behavioural CCD register on the first clock
// Assumes: One pixel moves per clock rise
// Notes: A sensor whose driver is off does not shift
module ccd_sensor_model (
    // Clock and drive
    input wire logic pclk,
    input wire logic horizontal_clock_one,
    input wire logic h1_oe_n,
    // Pixel to the converter
    output logic [13:0] pixel
);
    timeunit 1ns;
    timeprecision 1ps;
    logic prev = 1'b0;
    initial pixel = 14'h2A5C;
    // Shift on a rise while driven
    always @(posedge pclk) begin
        prev <= horizontal_clock_one;
        if (!h1_oe_n && horizontal_clock_one && !prev)
            pixel <= pixel + 14'h0113;
    end
endmodule // ccd_sensor_model

// ---- verif/ccd_fine_edge_timing_gen_test.sv ----
// Purpose: Self-checking bench for the timing generator
// Assumes: pclk 100 MHz, one fine step a cycle
// Notes: Reads are checked from a queue of expected words
module ccd_fine_edge_timing_gen_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, line_sync_input = 1'b1, pre_blanking = 1'b0;
    logic gain_update = 1'b0, optical_black_clamp = 1'b0;
    logic [11:0] paddr = 12'h000, pixel_count;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'h30;
    logic [13:0] conv_data, clamp_level = 14'h0, data_out;
    logic [14:0] driver_current_codes;
    logic [3:0] hclk_oe_n;
    logic pready, pslverr, h1, h2, rg, stby, pdn, data_out_oe_n, rbyp;
    logic [32:0] expq[$];
    int n_fail = 0, cmp_count = 0;

    ccd_fine_edge_timing_gen u_dut (.pclk, .presetn, .clk_en(1'b1), .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .line_sync_input, .conv_data, .clamp_level, .pre_blanking,
        .optical_black_clamp, .gain_update, .reset_gate_pulse(rg),
        .horizontal_clock_one(h1), .horizontal_clock_two(h2),
        .horizontal_clock_three(), .horizontal_clock_four(),
        .reset_level_strobe(), .data_level_strobe(), .driver_current_codes,
        .hclk_oe_n, .reset_gate_oe_n(), .data_out, .data_out_oe_n,
        .power_state_select(), .reference_standby(stby),
        .total_power_down(pdn), .clamp_active(), .clamp_settling_speed(),
        .quick_clamp_pulse(), .restore_bypassed(rbyp), .pixel_count);
    ccd_sensor_model u_ccd (.pclk, .horizontal_clock_one(h1),
        .h1_oe_n(hclk_oe_n[0]), .pixel(conv_data));

    always #5 pclk = ~pclk;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string nm, input logic [32:0] e, g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (n >= 20) n_fail++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        expq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Length of one high run of a waveform
    task automatic meas(input bit sel, output int n);
        int k = 0;
        n = 0;
        while ((sel ? rg : h1) !== 1'b0 && k < 60) begin
            k++;
            @(posedge pclk);
        end
        while ((sel ? rg : h1) !== 1'b1 && k < 120) begin
            k++;
            @(posedge pclk);
        end
        while ((sel ? rg : h1) === 1'b1 && n < 60) begin
            n++;
            @(posedge pclk);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Completed reads take the oldest note
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk("prdata", expq.size() ? expq.pop_front() : 33'h0,
                {pslverr, prdata});

    // Random clamp events
    always @(posedge pclk)
        {gain_update, optical_black_clamp} <= 2'(xs());

    // Hang guard, some thirty times the run
    initial begin
        #300us;
        n_fail++;
        report_and_stop();
    end

    initial begin : main
        int n;
        logic [31:0] d;
        wt(8);
        presetn <= 1'b1;
        rd(12'h000, 33'h004);
        rd(12'h00C, 33'h004);
        rd(12'h188, 33'h000);
        rd(12'h190, 33'h000);
        rd(12'h040, 33'h100000000);
        $display("test reset_values done");
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, 12'h000, 32'h1D4 | p);
            wt(3);
            chk("power", {p > 1, p == 1}, {pdn, stby});
        end
        rd(12'h000, 33'h1D7);
        $display("test power done");
        clamp_level <= 14'(xs());
        apb(1'b1, 12'h00C, 32'h30);
        wt(3);
        chk("gray", conv_data ^ (conv_data >> 1), data_out);
        apb(1'b1, 12'h00C, 32'h10);
        wt(3);
        chk("binary", conv_data, data_out);
        pre_blanking <= 1'b1;
        wt(3);
        chk("blank zero", 33'h0, data_out);
        apb(1'b1, 12'h000, 32'h1F4);
        wt(3);
        chk("blank clamp", clamp_level, data_out);
        chk("bypass", 33'h1, rbyp);
        pre_blanking <= 1'b0;
        apb(1'b1, 12'h00C, 32'h18);
        wt(3);
        chk("tristate", 33'h1, data_out_oe_n);
        $display("test output_word done");
        d = xs() & 32'h7FFF;
        apb(1'b1, 12'h188, d);
        rd(12'h188, {1'b0, d});
        chk("drive", d[14:0], driver_current_codes);
        // Rise at 5, fall at 41: high 36 steps, or 12 inverted
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, i[1] ? 12'h184 : 12'h180, 32'h1A8A | i[0]);
            wt(100);
            meas(i[1], n);
            chk("high steps", i[0] ? 12 : 36, n);
        end
        $display("test edges done");
        line_sync_input <= 1'b0;
        n = 0;
        @(posedge pclk);
        while (pixel_count !== 12'h000 && n < 500) begin
            n++;
            @(posedge pclk);
        end
        chk("sync delay", 33'h1, n >= 288 && n <= 432);
        $display("test line_sync done");
        report_and_stop();
    end
endmodule // ccd_fine_edge_timing_gen_test
